// file: fac_consts.vh
// Register offsets, field positions, reset values, sector size, CRC constants and response codes for the auto CRC block
`ifndef FAC_CONSTS_VH
`define FAC_CONSTS_VH
`define FAC_IDX_INPUT 8'h93
`define FAC_IDX_CTRL 8'h94
`define FAC_IDX_FLIP 8'h95
`define FAC_IDX_AUTO 8'h96
`define FAC_IDX_CNT 8'h97
`define FAC_IDX_RESULT 8'h98
`define FAC_IDX_STATUS 8'h99
`define FAC_IDX_ENABLE 8'h9a
`define FAC_IDX_CLEAR 8'h9b
`define FAC_AUTO_EN_BIT 7
`define FAC_AUTO_DONE_BIT 6
`define FAC_AUTO_RESET 8'h40
`define FAC_CNT_RESET 8'h00
`define FAC_FLIP_RESET 8'h00
`define FAC_SECTOR_BYTES 1024
`define FAC_SECTOR_SHIFT 10
`define FAC_CRC_INIT 32'hffffffff
`define FAC_CRC_POLY 32'hedb88320
`define FAC_RESP_OKAY 2'b00
`define FAC_RESP_SLVERR 2'b10
`endif

// file: fac_auto_crc.v
// Automatic Flash CRC controller, bit reverse register and AXI4-Lite register slave
`timescale 1ns/1ps
`include "fac_consts.vh"

// Overview of operation
// - With auto_calc_enable set, any write with byte lane 0 strobed to control register launches a Flash CRC run.
// - auto_calc_complete is 0 during a run, but reads stall until it is back to 1; it resets to 1.
// - Processor is stalled for the whole run.
// - First Flash byte address is start_sector times 1024.
// - Last sector processed starts at (start_sector plus sector_count) times 1024.
// - Upper two bits of sector count register read zero; writes ignored.
// - Bit reverse register returns last written byte with bit order reversed.
// - Every software or Flash byte is folded into the existing CRC result.
module fac_auto_crc #(
   parameter ADDR_WIDTH = 16
) (
   input wire clock,
   input wire rst_n,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [ADDR_WIDTH-1:0] flashAddr,
   output reg flashRead,
   input wire [7:0] flashData,
   output reg cpuStall,
   output reg irq
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;
   localparam [7:0] AUTO_RESET = `FAC_AUTO_RESET;

   // Reflected CRC-32 of one byte folded into the running value
   function [31:0] crcByte;
      input [31:0] crcIn;
      input [7:0] dataIn;
      integer i;
      reg [31:0] c;
      begin
         c = crcIn ^ {24'h000000, dataIn};
         for (i = 0; i < 8; i = i + 1) begin
            c = c[0] ? ((c >> 1) ^ `FAC_CRC_POLY) : (c >> 1);
         end
         crcByte = c;
      end
   endfunction

   function [7:0] flipByte;
      input [7:0] b;
      integer i;
      begin
         flipByte = 8'h00;
         for (i = 0; i < 8; i = i + 1) begin
            flipByte[i] = b[7 - i];
         end
      end
   endfunction

   reg state;
   reg autoEnable;
   reg autoComplete;
   reg [5:0] startSector;
   reg [5:0] sectorCount;
   reg [7:0] flipStore;
   reg [31:0] crcResult;
   reg [ADDR_WIDTH-1:0] lastAddr;
   reg fetchPending;
   reg [1:0] status;
   reg [1:0] intEnable;
   reg [11:0] awAddrHeld;
   reg awHeld;
   reg [31:0] wDataHeld;
   reg [3:0] wStrbHeld;
   reg wHeld;

   wire [ADDR_WIDTH-1:0] sectorBase = {{(ADDR_WIDTH-6){1'b0}}, startSector} << `FAC_SECTOR_SHIFT;
   wire [6:0] lastSector = {1'b0, startSector} + {1'b0, sectorCount};
   wire [ADDR_WIDTH-1:0] lastStart = {{(ADDR_WIDTH-7){1'b0}}, lastSector} << `FAC_SECTOR_SHIFT;
   wire [ADDR_WIDTH-1:0] lastByte = lastStart | {{(ADDR_WIDTH-`FAC_SECTOR_SHIFT){1'b0}}, {`FAC_SECTOR_SHIFT{1'b1}}};

   wire awGot = awHeld | s_axi_awvalid;
   wire wGot = wHeld | s_axi_wvalid;
   wire [11:0] wrAddr = awHeld ? awAddrHeld : s_axi_awaddr;
   wire [31:0] wrData = wHeld ? wDataHeld : s_axi_wdata;
   wire [3:0] wrStrb = wHeld ? wStrbHeld : s_axi_wstrb;
   // A register write completes only when the block is idle; a run holds the bus off
   wire doWrite = awGot & wGot & ~s_axi_bvalid & (state == ST_IDLE);
   wire [9:0] wrIdx = wrAddr[11:2];
   wire wrByte0 = wrStrb[0];
   wire wrInput = doWrite & wrByte0 & (wrIdx == {2'b00, `FAC_IDX_INPUT});
   wire wrCtrl = doWrite & wrByte0 & (wrIdx == {2'b00, `FAC_IDX_CTRL});
   wire launch = wrCtrl & autoEnable;
   wire runEnd = (state == ST_RUN) & fetchPending & (flashAddr == lastAddr);
   wire doRead = s_axi_arvalid & s_axi_arready;
   wire [9:0] rdIdx = s_axi_araddr[11:2];

   // Write channels: each captured independently, response after both
   always @(posedge clock) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrHeld <= 12'h000;
         wDataHeld <= 32'h00000000;
         wStrbHeld <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FAC_RESP_OKAY;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         if (s_axi_awvalid & ~awHeld & ~s_axi_awready) begin
            awHeld <= 1'b1;
            awAddrHeld <= s_axi_awaddr;
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid & ~wHeld & ~s_axi_wready) begin
            wHeld <= 1'b1;
            wDataHeld <= s_axi_wdata;
            wStrbHeld <= s_axi_wstrb;
            s_axi_wready <= 1'b1;
         end
         if (doWrite & awHeld & wHeld) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wrIdx >= {2'b00, `FAC_IDX_INPUT} && wrIdx <= {2'b00, `FAC_IDX_CLEAR}) ?
               `FAC_RESP_OKAY : `FAC_RESP_SLVERR;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   wire commit = doWrite & awHeld & wHeld;

   // Register file and automatic run sequencer
   always @(posedge clock) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         autoEnable <= AUTO_RESET[`FAC_AUTO_EN_BIT];
         autoComplete <= AUTO_RESET[`FAC_AUTO_DONE_BIT];
         startSector <= 6'h00;
         sectorCount <= 6'h00;
         flipStore <= `FAC_FLIP_RESET;
         crcResult <= `FAC_CRC_INIT;
         flashAddr <= {ADDR_WIDTH{1'b0}};
         flashRead <= 1'b0;
         fetchPending <= 1'b0;
         lastAddr <= {ADDR_WIDTH{1'b0}};
         cpuStall <= 1'b0;
         status <= 2'b00;
         intEnable <= 2'b00;
         irq <= 1'b0;
      end else begin
         irq <= |(status & intEnable);
         if (commit & wrByte0) begin
            case (wrIdx)
               {2'b00, `FAC_IDX_INPUT}: crcResult <= crcByte(crcResult, wrData[7:0]);
               {2'b00, `FAC_IDX_CTRL}: if (!wrData[0]) crcResult <= `FAC_CRC_INIT;
               {2'b00, `FAC_IDX_FLIP}: flipStore <= wrData[7:0];
               {2'b00, `FAC_IDX_AUTO}: begin
                  autoEnable <= wrData[`FAC_AUTO_EN_BIT];
                  startSector <= wrData[5:0];
               end
               {2'b00, `FAC_IDX_CNT}: sectorCount <= wrData[5:0];
               {2'b00, `FAC_IDX_ENABLE}: intEnable <= wrData[1:0];
               default: ;
            endcase
         end
         // Clear first so a same-cycle event still sets its bit
         if (commit & wrByte0 & (wrIdx == {2'b00, `FAC_IDX_CLEAR})) begin
            status <= status & ~wrData[1:0];
         end
         if (wrInput & commit) begin
            status[1] <= 1'b1;
         end
         case (state)
            ST_IDLE: begin
               if (launch & commit) begin
                  state <= ST_RUN;
                  autoComplete <= 1'b0;
                  cpuStall <= 1'b1;
                  flashAddr <= sectorBase;
                  lastAddr <= lastByte;
                  flashRead <= 1'b1;
                  fetchPending <= 1'b0;
               end
            end
            ST_RUN: begin
               fetchPending <= flashRead;
               if (fetchPending) begin
                  crcResult <= crcByte(crcResult, flashData);
               end
               if (runEnd) begin
                  state <= ST_IDLE;
                  autoComplete <= 1'b1;
                  cpuStall <= 1'b0;
                  flashRead <= 1'b0;
                  fetchPending <= 1'b0;
                  status[0] <= 1'b1;
               end else if (fetchPending) begin
                  flashAddr <= flashAddr + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
                  // The last byte is fetched as well; runEnd closes the run once it is folded
                  flashRead <= 1'b1;
               end else begin
                  flashRead <= 1'b0;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Read channel; reads stall during a run, so the flag is always seen as 1
   always @(posedge clock) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `FAC_RESP_OKAY;
      end else begin
         // A read must not slip in at the edge that launches a run
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid & (state == ST_IDLE) & ~(launch & commit);
         if (doRead) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `FAC_RESP_OKAY;
            case (rdIdx)
               {2'b00, `FAC_IDX_FLIP}: s_axi_rdata <= {24'h000000, flipByte(flipStore)};
               {2'b00, `FAC_IDX_AUTO}: s_axi_rdata <= {24'h000000, autoEnable, autoComplete, startSector};
               {2'b00, `FAC_IDX_CNT}: s_axi_rdata <= {24'h000000, 2'b00, sectorCount};
               {2'b00, `FAC_IDX_RESULT}: s_axi_rdata <= crcResult;
               {2'b00, `FAC_IDX_STATUS}: s_axi_rdata <= {30'h00000000, status};
               {2'b00, `FAC_IDX_ENABLE}: s_axi_rdata <= {30'h00000000, intEnable};
               {2'b00, `FAC_IDX_INPUT}, {2'b00, `FAC_IDX_CTRL}, {2'b00, `FAC_IDX_CLEAR}:
                  s_axi_rdata <= 32'h00000000;
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `FAC_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// file: fac_flash_model.sv
// Flash read port model with one cycle read latency
`timescale 1ns/1ps
module fac_flash_model (
   input wire clock,
   input wire flashRead,
   input wire [15:0] flashAddr,
   output reg [7:0] flashData
);
   initial flashData = 8'h00;
   // Idle port inverts its previous output every cycle, so a stale sample cannot pass
   always @(posedge clock) begin
      flashData <= flashRead ? flashAddr[7:0] ^ flashAddr[15:8] : ~flashData;
   end
endmodule

// file: fac_auto_crc_asserts.sv
// Port assertions for the auto CRC block
`timescale 1ns/1ps
module fac_auto_crc_asserts #(
   parameter ADDR_WIDTH = 16
) (
   input wire clock,
   input wire rst_n,
   input wire s_axi_arready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [ADDR_WIDTH-1:0] flashAddr,
   input wire flashRead,
   input wire cpuStall
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   AST_RUN_START: assert property ($rose(cpuStall) |-> flashRead && flashAddr[9:0] == 10'h000)
      else $error("run did not start on a sector boundary");
   AST_READ_IN_RUN: assert property (flashRead |-> cpuStall)
      else $error("flash fetch outside a stalled run");
   AST_NO_AR_IN_RUN: assert property (cpuStall |-> !s_axi_arready)
      else $error("read accepted during a run");
   AST_NO_R_IN_RUN: assert property (cpuStall |-> !$rose(s_axi_rvalid))
      else $error("read answered during a run");
   AST_ADDR_STEP: assert property (flashRead && $past(flashRead, 2) |-> flashAddr == $past(flashAddr, 2) + 16'd1)
      else $error("flash address skipped");
   AST_STALL_END: assert property ($fell(cpuStall) |-> !flashRead)
      else $error("flash fetch after the stall released");
   AST_RUN_MIN: assert property ($rose(cpuStall) |-> cpuStall [*8])
      else $error("run ended too early");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   cover property ($rose(cpuStall));
   cover property ($fell(cpuStall));
   cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind fac_auto_crc fac_auto_crc_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) i_fac_auto_crc_asserts (.*);

// file: tb_fac_auto_crc.sv
// Self-checking bench for the auto CRC block
`timescale 1ns/1ps
`include "fac_consts.vh"
module tb_fac_auto_crc;
   reg clock, rst_n, awv, wv, bready, arv, rready;
   reg [11:0] awaddr, araddr;
   reg [31:0] wdata, rv, e;
   reg [1:0] rr, br;
   reg [15:0] firstA, lastA;
   reg seen;
   wire awready, wready, bvalid, arready, rvalid, flashRead, cpuStall, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] flashAddr;
   wire [7:0] flashData;
   integer n_fail, num_checks, cyc, a;
   fac_auto_crc i_fac_auto_crc (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flashAddr(flashAddr), .flashRead(flashRead),
      .flashData(flashData), .cpuStall(cpuStall), .irq(irq));
   fac_flash_model i_fac_flash_model (.clock(clock), .flashRead(flashRead), .flashAddr(flashAddr),
      .flashData(flashData));
   initial begin
      clock = 0;
      forever #20 clock = ~clock;
   end
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_fail);
         if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [8*10:1] nm, input [31:0] seenV, input [31:0] expV);
      begin
         num_checks = num_checks + 1;
         if (seenV !== expV) begin
            n_fail = n_fail + 1;
            $display("wrong value %0s expected %h seen %h", nm, expV, seenV);
         end
      end
   endtask
   task wr(input [7:0] i, input [31:0] d);
      begin
         @(posedge clock);
         awaddr <= {2'b00, i, 2'b00};
         wdata <= d;
         awv <= 1;
         wv <= 1;
         bready <= 1;
         do begin
            @(posedge clock);
            if (awready) awv <= 0;
            if (wready) wv <= 0;
         end while (!bvalid);
         br = bresp;
         bready <= 0;
      end
   endtask
   task rd(input [7:0] i);
      begin
         @(posedge clock);
         araddr <= {2'b00, i, 2'b00};
         arv <= 1;
         rready <= 1;
         do begin
            @(posedge clock);
            if (arready) arv <= 0;
         end while (!rvalid);
         rv = rdata;
         rr = rresp;
         rready <= 0;
      end
   endtask
   function [31:0] crcb(input [31:0] c, input [7:0] d);
      integer k;
      begin
         c = c ^ d;
         for (k = 0; k < 8; k = k + 1) c = c[0] ? (c >> 1) ^ `FAC_CRC_POLY : c >> 1;
         crcb = c;
      end
   endfunction
   task t_regs;
      begin
         rd(`FAC_IDX_AUTO); chk("auto", rv, 32'h40);
         rd(`FAC_IDX_CNT); chk("count", rv, 32'h0);
         rd(`FAC_IDX_FLIP); chk("flip", rv, 32'h0);
         rd(8'h00); chk("unmapped", rr, `FAC_RESP_SLVERR);
         wr(8'h00, 32'h0); chk("bresp", br, `FAC_RESP_SLVERR);
         wr(`FAC_IDX_FLIP, 32'hc0); rd(`FAC_IDX_FLIP); chk("flip", rv, 32'h03);
         chk("bresp", br, `FAC_RESP_OKAY);
         wr(`FAC_IDX_FLIP, 32'h05); rd(`FAC_IDX_FLIP); chk("flip", rv, 32'ha0);
         wr(`FAC_IDX_CNT, 32'hff); rd(`FAC_IDX_CNT); chk("count", rv, 32'h3f);
      end
   endtask
   task t_auto;
      begin
         wr(`FAC_IDX_CNT, 32'h00);
         wr(`FAC_IDX_CTRL, 32'h00);
         wr(`FAC_IDX_AUTO, 32'h82);
         seen = 0;
         // The launching write is answered at once; the stall then holds off the next access
         wr(`FAC_IDX_CTRL, 32'h01);
         chk("stall", cpuStall, 1'b1);
         rd(`FAC_IDX_AUTO); chk("auto", rv, 32'hc2);
         chk("stall", cpuStall, 1'b0);
         chk("first", firstA, 16'd2048);
         chk("last", lastA, 16'd3071);
         e = `FAC_CRC_INIT;
         for (a = 2048; a < 3072; a = a + 1) e = crcb(e, a[7:0] ^ a[15:8]);
         rd(`FAC_IDX_RESULT); chk("result", rv, e);
         wr(`FAC_IDX_INPUT, 32'h5a);
         rd(`FAC_IDX_RESULT); chk("result", rv, crcb(e, 8'h5a));
         rd(`FAC_IDX_STATUS); chk("status", rv[0], 1'b1);
         chk("status", rv[1], 1'b1);
         chk("irq", irq, 1'b0);
         wr(`FAC_IDX_ENABLE, 32'h01);
         repeat (2) @(posedge clock);
         chk("irq", irq, 1'b1);
         wr(`FAC_IDX_CLEAR, 32'h03);
         repeat (2) @(posedge clock);
         chk("irq", irq, 1'b0);
      end
   endtask
   always @(posedge clock) begin
      if (flashRead) begin
         if (!seen) firstA = flashAddr;
         seen = 1;
         lastA = flashAddr;
      end
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         print_verdict;
      end
   end
   initial begin
      {rst_n, awv, wv, bready, arv, rready, seen} = 0;
      {awaddr, araddr, wdata, firstA, lastA} = 0;
      {n_fail, num_checks, cyc} = 0;
      repeat (2) @(posedge clock);
      rst_n <= 1;
      t_regs;
      t_auto;
      print_verdict;
   end
endmodule
